// [include/fbc_pkg.sv]
package fbc_pkg;
    localparam int unsigned FBC_CLK_HZ = 10_000_000;
    localparam int unsigned FBC_TICK_MS = 100;
    localparam int unsigned FBC_TICK_CYC = FBC_CLK_HZ / 1000 * FBC_TICK_MS;
    localparam int unsigned FBC_START_MS = 1000;
    localparam int unsigned FBC_PAUSE_MS = 2000;
    localparam int unsigned FBC_ON_MS = 100;
    localparam int unsigned FBC_OFF_MS = 400;
    localparam int unsigned FBC_DARK_MS = 100;
    localparam logic [4:0] FBC_START_TK = 5'(FBC_START_MS / FBC_TICK_MS);
    localparam logic [4:0] FBC_PAUSE_TK = 5'(FBC_PAUSE_MS / FBC_TICK_MS);
    localparam logic [4:0] FBC_ON_TK = 5'(FBC_ON_MS / FBC_TICK_MS);
    localparam logic [4:0] FBC_OFF_TK = 5'(FBC_OFF_MS / FBC_TICK_MS);
    localparam logic [4:0] FBC_DARK_TK = 5'(FBC_DARK_MS / FBC_TICK_MS);
    localparam logic [3:0] FBC_ZERO_FLASHES = 4'hA;
    localparam int unsigned FBC_NCODES = 16;
    localparam int unsigned FBC_IDXW = 4;

    typedef enum logic [6:0] {
        FBC_IDLE  = 7'h01,
        FBC_DARK  = 7'h02,
        FBC_START = 7'h04,
        FBC_PAUSE = 7'h08,
        FBC_ON    = 7'h10,
        FBC_OFF   = 7'h20,
        FBC_GAP   = 7'h40
    } fbc_state_type;
endpackage

// [include/fbc_tick_if.sv]
`timescale 1ns/1ns
interface fbc_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// [rtl/fbc_tick_gen.sv]
`timescale 1ns/1ns
module fbc_tick_gen #(
    parameter int unsigned CYC = fbc_pkg::FBC_TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Timebase
    fbc_tick_if.src tk
);
    import fbc_pkg::*;
    logic [19:0] cnt_r;
    wire logic wrap = (cnt_r == 20'(CYC - 1));

    always_ff @(posedge clk) begin
        if (sys_rst || wrap) begin
            cnt_r <= 20'h00000;
        end else begin
            cnt_r <= cnt_r + 20'h00001;
        end
    end
    assign tk.tick = wrap;
endmodule

// [rtl/fbc_sequencer.sv]
`timescale 1ns/1ns
// Behaviour
// - Any active fault makes the indicator LED flash, never hold steady.
// - If LED was lit by raised catch bar, switch it off first.
// - Each code opens with 1 s LED on, then 2 s off.
// - Each flash is 0.1 s on then 0.4 s off.
// - Flash count equals digit value, then a pause.
// - Tens digit group, pause, units digit group.
// - A zero digit is shown as ten flashes.
// - Several active codes shown in turn, each with its own start signal.
// - A code repeats while its fault is active and stops once cleared.
module fbc_sequencer #(
    parameter int unsigned TICK_CYC = fbc_pkg::FBC_TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fault flags, bit n means code n, from controller logic
    input wire logic [fbc_pkg::FBC_NCODES-1:0] fault_act,
    // Catch bar raised, from a pin
    input wire logic bar_raised,
    // LED
    output logic led_on
);
    import fbc_pkg::*;

    fbc_tick_if tk ();
    fbc_tick_gen #(.CYC(TICK_CYC)) u_tick (.clk(clk), .sys_rst(sys_rst), .tk(tk));

    logic bar_s1_r, bar_s2_r;
    fbc_state_type st_r, st_nxt;
    logic [4:0] tmr_r, tmr_nxt;
    logic [FBC_IDXW-1:0] code_r, code_nxt;
    logic units_r, units_nxt;
    logic [3:0] left_r, left_nxt;
    logic led_r, led_nxt;

    function automatic logic [3:0] fbc_flashes(input logic [3:0] d);
        return (d == 4'h0) ? FBC_ZERO_FLASHES : d;
    endfunction

    // Next active code at or after a start index, wrapping round
    function automatic logic [FBC_IDXW-1:0] fbc_pick(input logic [FBC_NCODES-1:0] f,
                                                     input logic [FBC_IDXW-1:0] from);
        logic [FBC_IDXW-1:0] r;
        logic found;
        r = from;
        found = 1'b0;
        for (int i = 0; i < FBC_NCODES; i++) begin
            if (!found && f[FBC_IDXW'(from + FBC_IDXW'(i))]) begin
                r = FBC_IDXW'(from + FBC_IDXW'(i));
                found = 1'b1;
            end
        end
        return r;
    endfunction

    wire logic any_fault = |fault_act;
    wire logic [3:0] tens_d = 4'(code_r / 10);
    wire logic [3:0] unit_d = 4'(code_r % 10);
    wire logic two_digit = (tens_d != 4'h0);
    wire logic tmr_done = tk.tick && (tmr_r == 5'h01);
    wire logic [FBC_IDXW-1:0] next_code = fbc_pick(fault_act, FBC_IDXW'(code_r + 1'b1));
    wire logic [FBC_IDXW-1:0] first_code = fbc_pick(fault_act, code_r);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bar_s1_r <= 1'b0;
            bar_s2_r <= 1'b0;
        end else begin
            bar_s1_r <= bar_raised;
            bar_s2_r <= bar_s1_r;
        end
    end

    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tk.tick ? tmr_r - 5'h01 : tmr_r;
        code_nxt = code_r;
        units_nxt = units_r;
        left_nxt = left_r;
        led_nxt = 1'b0;
        case (st_r)
            FBC_IDLE: begin
                led_nxt = bar_s2_r;
                if (any_fault) begin
                    code_nxt = first_code;
                    if (bar_s2_r) begin
                        st_nxt = FBC_DARK;
                        tmr_nxt = FBC_DARK_TK;
                        led_nxt = 1'b0;
                    end else begin
                        st_nxt = FBC_START;
                        tmr_nxt = FBC_START_TK;
                        led_nxt = 1'b1;
                    end
                end
            end
            FBC_DARK: begin
                if (tmr_done) begin
                    st_nxt = FBC_START;
                    tmr_nxt = FBC_START_TK;
                    led_nxt = 1'b1;
                end
            end
            FBC_START: begin
                led_nxt = 1'b1;
                if (tmr_done) begin
                    st_nxt = FBC_PAUSE;
                    tmr_nxt = FBC_PAUSE_TK;
                    led_nxt = 1'b0;
                    units_nxt = !two_digit;
                    left_nxt = two_digit ? tens_d : fbc_flashes(unit_d);
                end
            end
            FBC_PAUSE: begin
                if (tmr_done) begin
                    st_nxt = FBC_ON;
                    tmr_nxt = FBC_ON_TK;
                    led_nxt = 1'b1;
                end
            end
            FBC_ON: begin
                led_nxt = 1'b1;
                if (tmr_done) begin
                    st_nxt = FBC_OFF;
                    tmr_nxt = FBC_OFF_TK;
                    led_nxt = 1'b0;
                    left_nxt = left_r - 4'h1;
                end
            end
            FBC_OFF: begin
                if (tmr_done) begin
                    if (left_r != 4'h0) begin
                        st_nxt = FBC_ON;
                        tmr_nxt = FBC_ON_TK;
                        led_nxt = 1'b1;
                    end else begin
                        st_nxt = FBC_GAP;
                        tmr_nxt = FBC_PAUSE_TK;
                    end
                end
            end
            FBC_GAP: begin
                if (tmr_done) begin
                    if (!units_r) begin
                        st_nxt = FBC_ON;
                        tmr_nxt = FBC_ON_TK;
                        led_nxt = 1'b1;
                        units_nxt = 1'b1;
                        left_nxt = fbc_flashes(unit_d);
                    end else if (any_fault) begin
                        code_nxt = next_code;
                        st_nxt = FBC_START;
                        tmr_nxt = FBC_START_TK;
                        led_nxt = 1'b1;
                    end else begin
                        st_nxt = FBC_IDLE;
                        led_nxt = bar_s2_r;
                    end
                end
            end
            default: begin
                st_nxt = FBC_IDLE;
            end
        endcase
    end

    // Sequence ends only at a code boundary so a half-shown code is never cut
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= FBC_IDLE;
            tmr_r <= 5'h00;
            code_r <= '0;
            units_r <= 1'b0;
            left_r <= 4'h0;
            led_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            code_r <= code_nxt;
            units_r <= units_nxt;
            left_r <= left_nxt;
            led_r <= led_nxt;
        end
    end

    assign led_on = led_r;

    // Checks
    sequence s_start_led;
        (st_r == FBC_START) && led_r;
    endsequence

    a_start_led_on: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == FBC_START) |-> led_r)
        else $error("LED off during start signal");
    a_pause_dark: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r inside {FBC_PAUSE, FBC_GAP, FBC_DARK}) |-> !led_r)
        else $error("LED lit during pause");
    a_flash_on: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == FBC_ON) |-> led_r && (tmr_r <= FBC_ON_TK))
        else $error("Flash on phase wrong");
    a_flash_off: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == FBC_OFF) |-> !led_r && (tmr_r <= FBC_OFF_TK))
        else $error("Flash off phase wrong");
    a_bar_dark_first: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == FBC_IDLE && any_fault && bar_s2_r) |=> (st_r == FBC_DARK) && !led_r)
        else $error("Start not preceded by dark");
    a_idle_follows: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == FBC_IDLE) ##1 (st_r == FBC_IDLE) |-> (led_r == $past(bar_s2_r)))
        else $error("Idle LED not following bar");
    a_fault_flash: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == FBC_IDLE && any_fault) |=> (st_r != FBC_IDLE))
        else $error("Fault not shown");
    a_zero_ten: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == FBC_GAP && tmr_done && !units_r && unit_d == 4'h0) |=> (left_r == 4'hA))
        else $error("Zero digit not ten flashes");
    a_start_pause: assert property (@(posedge clk) disable iff (sys_rst)
        s_start_led ##1 (st_r == FBC_PAUSE) |-> (tmr_r == FBC_PAUSE_TK))
        else $error("Pause after start wrong");
    // Judged against the flags seen at the choice, so a flag that drops right after is no false alarm
    a_code_active: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == FBC_GAP && tmr_done && units_r && any_fault)
        |=> ((($past(fault_act) >> code_r) & 16'h0001) != 16'h0000))
        else $error("Inactive code chosen");
endmodule

// [bench/fbc_led_eye.sv]
`timescale 1ns/1ns
// Operator's eye on the LED: length of each finished level
module fbc_led_eye (
    // Clock
    input wire logic clk,
    // LED under watch
    input wire logic led_on,
    // Cycles of the last finished level
    output int last_len
);
    int cnt = 0;
    logic prev_r = 1'b0;
    always @(posedge clk) begin
        if (led_on !== prev_r) begin
            last_len <= cnt;
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
        prev_r <= led_on;
    end
endmodule

// [bench/tb_fault_blink_code_sequencer.sv]
`timescale 1ns/1ns
`define FBC_CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
    $display("[ERR] %s expected %0d seen %0d", nm, ex, got); end end
module tb_fault_blink_code_sequencer;
    localparam int CAP = 600;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] fault_act = 16'h0000;
    logic bar_raised = 1'b0;
    logic led_on;
    int seen_len;
    int miscompares = 0;
    int n_compared = 0;
    int n;

    fbc_sequencer #(.TICK_CYC(10)) u_dut (.clk(clk), .sys_rst(sys_rst), .fault_act(fault_act),
        .bar_raised(bar_raised), .led_on(led_on));
    fbc_led_eye u_eye (.clk(clk), .led_on(led_on), .last_len(seen_len));

    initial begin
        forever #50 clk = ~clk;
    end

    // Length of the level now shown; a steady level reads as CAP
    task automatic run(input logic lvl, output int len);
        int w;
        w = 0;
        while (led_on === lvl && w < CAP) begin
            @(negedge clk);
            w++;
        end
        if (w >= CAP) begin
            len = CAP;
        end else if (w == 0) begin
            len = 0;
        end else begin
            @(posedge clk);
            #1;
            len = seen_len;
        end
    endtask

    // Start may be short: the timebase phase runs free
    task automatic show_code(input int code, input bit more);
        int w, d, g, k, nf, len;
        int dg[2];
        w = 0;
        while (led_on !== 1'b1 && w < 3000) begin
            @(negedge clk);
            w++;
        end
        run(1'b1, len);
        `FBC_CHK("start", 1, int'(len >= 91 && len <= 100))
        run(1'b0, len);
        `FBC_CHK("pause", 200, len)
        g = (code >= 10) ? 2 : 1;
        dg[0] = (code >= 10) ? code / 10 : code;
        dg[1] = code % 10;
        for (d = 0; d < g; d++) begin
            nf = (dg[d] == 0) ? 10 : dg[d];
            for (k = 0; k < nf; k++) begin
                run(1'b1, len);
                `FBC_CHK("flash_on", 10, len)
                if (k < nf - 1) begin
                    run(1'b0, len);
                    `FBC_CHK("flash_off", 40, len)
                end
            end
            if (d < g - 1 || more) begin
                run(1'b0, len);
                `FBC_CHK("gap", 240, len)
            end
        end
    endtask

    task automatic test_two_digit;
        fault_act[14] = 1'b1;
        show_code(14, 1'b1);
        @(negedge clk);
        fault_act = 16'h0000;
        show_code(14, 1'b0);
        run(1'b0, n);
        `FBC_CHK("stop_dark", CAP, n)
    endtask

    task automatic test_bar_zero;
        bar_raised = 1'b1;
        repeat (5) @(negedge clk);
        `FBC_CHK("bar_idle", 1, int'(led_on === 1'b1))
        fault_act[10] = 1'b1;
        run(1'b1, n);
        run(1'b0, n);
        `FBC_CHK("dark_first", 1, int'(n >= 1 && n <= 10))
        @(negedge clk);
        fault_act = 16'h0000;
        show_code(10, 1'b0);
        run(1'b0, n);
        `FBC_CHK("tail", 240, n)
        run(1'b1, n);
        `FBC_CHK("bar_back", CAP, n)
    endtask

    // Last shown was 10, so 12 comes before the wrap to 3
    task automatic test_multi;
        bar_raised = 1'b0;
        repeat (5) @(negedge clk);
        fault_act[3] = 1'b1;
        fault_act[12] = 1'b1;
        show_code(12, 1'b1);
        show_code(3, 1'b1);
        @(negedge clk);
        fault_act = 16'h0000;
        show_code(12, 1'b0);
        run(1'b0, n);
        `FBC_CHK("multi_stop", CAP, n)
    endtask

    task automatic complete_run;
        $display("miscompares %0d n_compared %0d", miscompares, n_compared);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        test_two_digit();
        test_bar_zero();
        test_multi();
        complete_run();
    end
endmodule
